/* serial_port_pkg.sv */
// Shared constants, types and helpers for the three-wire serial port
package serial_port_pkg;

  // ==========================================================
  // Register map (byte addresses on the register bus)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] MODE_REG_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] TX_BUF_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] SHIFT_REG_ADDR = 8'h08;

  // ==========================================================
  // Field positions in the serial mode register
  localparam int ENABLE_POS = 7;
  localparam int TRMD_POS = 6;
  localparam int ORDER_POS = 4;
  localparam int FLAG_POS = 0;
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] TX_BUF_RESET = 8'h00;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic enable;
    logic trmd;
    logic lsb_first;
  } mode_t;

  localparam mode_t MODE_RESET = '0;

  typedef struct packed {
    logic sck;
    logic sdi;
  } pin_in_t;

  // Idle pin levels; the clock rests high, so reset must not fake a rise
  localparam pin_in_t PIN_IDLE = '{sck: 1'b1, sdi: 1'b0};

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_SHIFT = 1'b1
  } eng_state_t;

  // ==========================================================
  // Bit-order helpers
  // Bit that currently faces the data output pin
  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
    return lsb_first ? v[LSB_POS] : v[MSB_POS];
  endfunction

  // Shift one received bit in, pushing the sent bit out
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb_first,
                                          input logic b);
    return lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction

endpackage

/* pin_sync.sv */
// Two-stage synchroniser for the serial clock and data-in pins
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins from outside the clock domain
  input wire serial_port_pkg::pin_in_t async_in,
  // Synchronised copy
  output serial_port_pkg::pin_in_t synced
);
  import serial_port_pkg::*;

  pin_in_t stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= PIN_IDLE;
      synced <= PIN_IDLE;
    end else begin
      stage1_reg <= async_in;
      synced <= stage1_reg;
    end
  end
endmodule

/* serial_shift_engine.sv */
// Eight-bit shift engine: one bit in and one bit out per serial clock rise
`timescale 1ns/1ps
module serial_shift_engine (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control from the register side
  input wire logic clear,
  input wire logic start,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic lsb_first,
  // Link events, already synchronised
  input wire logic sck_rise,
  input wire logic sdi,
  // State
  output logic busy,
  output logic [7:0] shift_value,
  output logic out_value
);
  import serial_port_pkg::*;

  eng_state_t state_reg;
  logic [2:0] count_reg;
  wire last_rise = (state_reg == ENG_SHIFT) && sck_rise && (count_reg == LAST_BIT);

  assign busy = (state_reg == ENG_SHIFT);
  assign out_value = out_bit(shift_value, lsb_first);

  // State and bit count; clear acts at once and beats a start
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      state_reg <= ENG_IDLE;
      count_reg <= FIRST_BIT;
    end else if (start && state_reg == ENG_IDLE) begin
      state_reg <= ENG_SHIFT;
      count_reg <= FIRST_BIT;
    end else if (state_reg == ENG_SHIFT && sck_rise) begin
      count_reg <= count_reg + 3'h1;
      if (last_rise) begin
        state_reg <= ENG_IDLE;
      end
    end
  end

  // Shift register: parallel load, then full-duplex serial shift
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      shift_value <= SHIFT_RESET;
    end else if (start && load && state_reg == ENG_IDLE) begin
      shift_value <= load_data;
    end else if (state_reg == ENG_SHIFT && sck_rise) begin
      shift_value <= shift_in(shift_value, lsb_first, sdi);
    end
  end
endmodule

/* three_wire_serial_io.sv */
// Three-wire clocked serial port with AXI4-Lite register access
//
// Notes on behaviour
// - Only stop mode and three-wire mode exist.
// - Stop mode: no traffic, logic held idle.
// - Eight bits per transfer, clock plus two data lines.
// - Send and receive shift in the same transfer.
// - Software picks MSB-first or LSB-first order.
// - Buffer write starts transfer when enabled, transmit mode.
// - Buffer word loads shifter and drives data out.
// - Transmit buffer is read/write, reset value unimportant.
// - Eight-bit shifter, both directions, software readable.
// - Receive mode: shifter read starts a reception.
// - Reception shifts sampled data-in bits into shifter.
// - Reset clears the shifter to zero.
// - Clearing enable stops port, clears flag and shifter.
// - Receive-only mode holds data out low.
// - Read-only flag shows a transfer in progress.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module three_wire_serial_io (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [serial_port_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [serial_port_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial link pins
  input wire logic serial_clock_pin,
  input wire logic serial_data_in_pin,
  output logic serial_data_out_pin
);
  import serial_port_pkg::*;

  // ==========================================================
  // Declarations
  mode_t mode_reg;
  logic [7:0] tx_buf_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wlane_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic so_reg;
  logic sck_prev_reg;
  logic [3:0] rise_seen_reg;
  pin_in_t pins_raw;
  pin_in_t pins_sync;
  logic busy;
  logic [7:0] shift_value;
  logic out_value;

  // ==========================================================
  // Link side: synchronise pins and find serial clock rises
  assign pins_raw = '{sck: serial_clock_pin, sdi: serial_data_in_pin};

  pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_raw),
    .synced(pins_sync)
  );

  // Previous clock level, read only after both sync stages
  // Reset to the idle level so that release makes no false rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_prev_reg <= PIN_IDLE.sck;
    end else begin
      sck_prev_reg <= pins_sync.sck;
    end
  end

  wire sck_rise = pins_sync.sck && !sck_prev_reg;

  // ==========================================================
  // Write channel: address and data taken in either order
  assign awready = !aw_held_reg && !bvalid_reg;
  assign wready = !w_held_reg && !bvalid_reg;
  wire aw_fire = awvalid && awready;
  wire w_fire = wvalid && wready;
  wire have_aw = aw_held_reg || aw_fire;
  wire have_w = w_held_reg || w_fire;
  wire do_write = have_aw && have_w && !bvalid_reg;
  wire [ADDR_W-1:0] wr_addr = aw_held_reg ? waddr_reg : awaddr;
  wire [7:0] wr_byte = w_held_reg ? wbyte_reg : wdata[7:0];
  wire wr_lane = w_held_reg ? wlane_reg : wstrb[0];
  wire wr_is_mode = (wr_addr == MODE_REG_ADDR);
  wire wr_is_tx = (wr_addr == TX_BUF_ADDR);
  wire wr_is_shift = (wr_addr == SHIFT_REG_ADDR);
  wire wr_mapped = wr_is_mode || wr_is_tx || wr_is_shift;
  // Registers live in byte lane 0; other lanes are ignored
  wire wr_mode = do_write && wr_is_mode && wr_lane;
  wire wr_tx = do_write && wr_is_tx && wr_lane;

  // Hold whichever half arrived first until the other joins it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= awaddr;
      end
      if (w_fire) begin
        w_held_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
    end
  end

  // Write response; shifter is read-only, so a write there is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // ==========================================================
  // Mode and transmit buffer registers
  // Mode bits written freely; the flag bit is read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      mode_reg.enable <= wr_byte[ENABLE_POS];
      mode_reg.trmd <= wr_byte[TRMD_POS];
      mode_reg.lsb_first <= wr_byte[ORDER_POS];
    end
  end

  // Plain read/write buffer; its reset value carries no meaning
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_reg <= TX_BUF_RESET;
    end else if (wr_tx) begin
      tx_buf_reg <= wr_byte;
    end
  end

  // ==========================================================
  // Transfer starts; a start while busy is ignored, not queued
  wire idle_enabled = mode_reg.enable && !busy;
  wire start_tx = wr_tx && idle_enabled && mode_reg.trmd;
  wire ar_fire = arvalid && arready;
  wire start_rx = ar_fire && (araddr == SHIFT_REG_ADDR) && idle_enabled
                  && !mode_reg.trmd;
  wire start_any = start_tx || start_rx;

  // Shifter runs full duplex: sends tx bits while taking sdi bits
  serial_shift_engine u_engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(!mode_reg.enable),
    .start(start_any),
    .load(start_tx),
    .load_data(wr_byte), // Incoming byte: the buffer only updates at this edge
    .lsb_first(mode_reg.lsb_first),
    .sck_rise(sck_rise),
    .sdi(pins_sync.sdi),
    .busy(busy),
    .shift_value(shift_value),
    .out_value(out_value)
  );

  // Data out forced low unless enabled in transmit/receive mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      so_reg <= 1'b0;
    end else begin
      so_reg <= mode_reg.enable && mode_reg.trmd && out_value;
    end
  end

  assign serial_data_out_pin = so_reg;

  // ==========================================================
  // Read channel: one read at a time, answered one cycle later
  assign arready = !rvalid_reg;
  wire [7:0] mode_view = {mode_reg.enable, mode_reg.trmd, 1'b0, mode_reg.lsb_first,
                          3'h0, busy};
  wire rd_is_mode = (araddr == MODE_REG_ADDR);
  wire rd_is_tx = (araddr == TX_BUF_ADDR);
  wire rd_is_shift = (araddr == SHIFT_REG_ADDR);
  wire rd_mapped = rd_is_mode || rd_is_tx || rd_is_shift;
  wire [7:0] rd_byte = rd_is_mode ? mode_view :
                       rd_is_tx ? tx_buf_reg :
                       rd_is_shift ? shift_value : 8'h00;

  // Read data latched at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= {24'h00_0000, rd_byte};
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  // ==========================================================
  // Checking helpers: count clock rises within a transfer
  always_ff @(posedge aclk) begin
    if (!aresetn || start_any) begin
      rise_seen_reg <= 4'h0;
    end else if (busy && sck_rise && rise_seen_reg != BITS_PER_WORD) begin
      rise_seen_reg <= rise_seen_reg + 4'h1;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  tx_start_a: assert property (
    start_tx |=> busy && shift_value == tx_buf_reg)
    else $error("transmit start did not load the shifter");

  rx_start_a: assert property (
    start_rx |=> busy)
    else $error("shifter read did not start reception");

  stop_clear_a: assert property (
    !mode_reg.enable |=> !busy && shift_value == SHIFT_RESET)
    else $error("disabled port kept state");

  out_low_a: assert property (
    !mode_reg.trmd ##1 !mode_reg.trmd |-> !serial_data_out_pin)
    else $error("data out not low in receive mode");

  flag_read_a: assert property (
    ar_fire && rd_is_mode |=> rdata[FLAG_POS] == $past(busy))
    else $error("status flag read mismatch");

  eight_bits_a: assert property (
    $fell(busy) && $past(mode_reg.enable) |-> $past(sck_rise)
      && $past(rise_seen_reg) == BITS_PER_WORD - 4'h1)
    else $error("transfer did not end on eighth clock rise");

  msb_shift_a: assert property (
    busy && sck_rise && mode_reg.enable && !mode_reg.lsb_first
      |=> shift_value[LSB_POS] == $past(pins_sync.sdi))
    else $error("MSB-first sample not shifted in");

  lsb_shift_a: assert property (
    busy && sck_rise && mode_reg.enable && mode_reg.lsb_first
      |=> shift_value[MSB_POS] == $past(pins_sync.sdi))
    else $error("LSB-first sample not shifted in");

  write_resp_a: assert property (
    do_write |=> bvalid ##0 (bresp == RESP_SLVERR) == !$past(wr_mapped))
    else $error("write response missing or wrong");

  read_resp_a: assert property (
    ar_fire |=> rvalid ##0 (rresp == RESP_SLVERR) == !$past(rd_mapped))
    else $error("read response missing or wrong");

  write_refuse_a: assert property (
    bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");

  // Link, shifter and transmit buffer checks
  stop_quiet_a: assert property (
    !mode_reg.enable |=> !serial_data_out_pin && !busy)
    else $error("stopped port still active");

  out_follow_a: assert property (
    mode_reg.enable && mode_reg.trmd |=> serial_data_out_pin == $past(out_value))
    else $error("data out does not follow the shifter");

  buf_write_a: assert property (
    wr_tx |=> tx_buf_reg == $past(wr_byte))
    else $error("transmit buffer write lost");

  shift_read_a: assert property (
    ar_fire && rd_is_shift |=> rdata[MSB_POS:LSB_POS] == $past(shift_value))
    else $error("shifter read mismatch");

  flag_set_a: assert property (
    $rose(busy) |-> $past(start_any))
    else $error("flag rose without a start");

  idle_hold_a: assert property (
    !busy && !start_any && mode_reg.enable |=> shift_value == $past(shift_value))
    else $error("idle shifter changed");

endmodule

/* serial_partner.sv */
// Behavioural peripheral on the far side of the three-wire link
`timescale 1ns/1ps
module serial_partner (
  // Link pins
  output logic serial_clock_pin,
  output logic serial_data_in_pin,
  input wire logic serial_data_out_pin
);
  // ==========================================================
  // Idle line levels
  // Clock stands high outside frames; data-in starts driven low
  initial begin
    serial_clock_pin = 1'b1;
    serial_data_in_pin = 1'b0;
  end

  // ==========================================================
  // One frame of eight clock periods, half period in ns
  // Data-in changes after the fall, data-out sampled on the rise
  task automatic run_frame(input logic [7:0] tx, input logic lsb_first,
                           input int half_ns, output logic [7:0] rx);
    int i;
    logic b;
    b = 1'b0;
    for (i = 0; i < 8; i++) begin
      serial_clock_pin = 1'b0;
      b = lsb_first ? tx[i] : tx[7-i];
      serial_data_in_pin = b;
      #(half_ns);
      serial_clock_pin = 1'b1;
      rx = lsb_first ? {serial_data_out_pin, rx[7:1]} : {rx[6:0], serial_data_out_pin};
      #(half_ns);
    end
    // Released line must not look like the last bit
    serial_data_in_pin = ~b;
  endtask
endmodule

/* three_wire_serial_io_tb_top.sv */
// Self-checking bench for the three-wire serial port
`timescale 1ns/1ps
module three_wire_serial_io_tb_top;
  import serial_port_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sck, sdi, sdo;
  int mismatches, compares;

  // ==========================================================
  // Design and far-side model
  three_wire_serial_io DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_clock_pin(sck), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo)
  );
  serial_partner partner (
    .serial_clock_pin(sck), .serial_data_in_pin(sdi), .serial_data_out_pin(sdo)
  );

  // ==========================================================
  // Clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========================================================
  // Reporting
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask

  function automatic logic [31:0] mode_word(input logic en, input logic trmd,
                                            input logic lsb);
    return (32'(en) << ENABLE_POS) | (32'(trmd) << TRMD_POS) | (32'(lsb) << ORDER_POS);
  endfunction

  // ==========================================================
  // AXI4-Lite master: readies sampled at the edge, before updates land
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        return;
      end
    end
    mismatches++;
    stop_test();
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        return;
      end
    end
    mismatches++;
    stop_test();
  endtask

  // ==========================================================
  // Scenarios
  // Stop mode: buffer usable, nothing shifts, unmapped refused
  task automatic test_stop_mode();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] got;
    axi_read(MODE_REG_ADDR, d, r);
    check(d, 32'h0);
    axi_read(SHIFT_REG_ADDR, d, r);
    check(d, {24'h0, SHIFT_RESET});
    axi_write(TX_BUF_ADDR, 32'h5a, r);
    axi_read(TX_BUF_ADDR, d, r);
    check(d, 32'h5a);
    axi_read(MODE_REG_ADDR, d, r);
    check(d, 32'h0);
    check({31'h0, sdo}, 32'h0);
    // A clocked frame while stopped must neither send nor shift
    partner.run_frame(8'ha5, 1'b0, 80, got);
    check({24'h0, got}, 32'h0);
    axi_read(SHIFT_REG_ADDR, d, r);
    check(d, {24'h0, SHIFT_RESET});
    axi_read(8'h0c, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
  endtask

  // Full duplex: buffer write starts, both directions land
  task automatic test_txrx(input logic lsb, input logic [7:0] tx, input logic [7:0] prx,
                           input int half);
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] got;
    axi_write(MODE_REG_ADDR, mode_word(1'b1, 1'b1, lsb), r);
    axi_write(TX_BUF_ADDR, {24'h0, tx}, r);
    axi_read(MODE_REG_ADDR, d, r);
    check(d, mode_word(1'b1, 1'b1, lsb) | 32'h1);
    // Software stays off the buffer and shifter during the frame
    partner.run_frame(prx, lsb, half, got);
    check({24'h0, got}, {24'h0, tx});
    axi_read(MODE_REG_ADDR, d, r);
    check(d, mode_word(1'b1, 1'b1, lsb));
    axi_read(SHIFT_REG_ADDR, d, r);
    check(d, {24'h0, prx});
  endtask

  // Receive-only, then disable in mid-transfer
  task automatic test_rx_only();
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] got;
    axi_write(MODE_REG_ADDR, mode_word(1'b1, 1'b0, 1'b0), r);
    axi_read(SHIFT_REG_ADDR, d, r);
    axi_read(MODE_REG_ADDR, d, r);
    check(d, mode_word(1'b1, 1'b0, 1'b0) | 32'h1);
    partner.run_frame(8'h96, 1'b0, 80, got);
    check({24'h0, got}, 32'h0);
    axi_read(SHIFT_REG_ADDR, d, r);
    check(d, 32'h96);
    axi_read(MODE_REG_ADDR, d, r);
    check(d, mode_word(1'b1, 1'b0, 1'b0) | 32'h1);
    axi_write(MODE_REG_ADDR, 32'h0, r);
    axi_read(MODE_REG_ADDR, d, r);
    check(d, 32'h0);
    axi_read(SHIFT_REG_ADDR, d, r);
    check(d, 32'h0);
    axi_write(SHIFT_REG_ADDR, 32'hff, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    axi_read(SHIFT_REG_ADDR, d, r);
    check(d, 32'h0);
    axi_write(8'h0c, 32'h1, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    mismatches = 0;
    compares = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_stop_mode();
    test_txrx(1'b0, 8'h1e, 8'hc4, 80);
    test_txrx(1'b1, 8'h1e, 8'hc4, 80);
    // End bits set in the sent byte and clear in the received byte
    test_txrx(1'b0, 8'h81, 8'h7e, 80);
    test_rx_only();
    stop_test();
  end
endmodule
